// ==== pkg/cell_monitor_defs.vh ====
`ifndef CELL_MONITOR_DEFS_VH
`define CELL_MONITOR_DEFS_VH

// register command bytes
`define REG_MODE_ADDR       8'h00
`define REG_BALANCE_ADDR    8'h01
`define REG_ANALOG_ADDR     8'h02
`define REG_OVERHEAT_ADDR   8'h06
`define REG_STATUS_ADDR     8'h07

// mode register 00h fields
`define MODE_SLEEP_HIGH_BIT 7
`define MODE_SLEEP_LOW_BIT  6
`define MODE_SCAN_EN_BIT    3
`define MODE_SEL_MSB        2
`define MODE_SEL_LSB        0

// analog control register 02h fields
`define ANA_CUR_MON_EN_BIT  0
`define ANA_ZERO_FORCE_BIT  1
`define ANA_GAIN_SEL_BIT    2
`define ANA_SHORT_EN_BIT    3

// overheat register 06h fields
`define OTD_DETECT_EN_BIT   7
`define OTD_LOCK_OPT_BIT    4
`define OTD_THRESH_MSB      1
`define OTD_THRESH_LSB      0

// status register 07h fields
`define ST_CHARGE_BIT       7
`define ST_DISCH_B_BIT      6
`define ST_DISCH_A_BIT      5
`define ST_OTD_BIT          4
`define ST_WAKE_TWO_BIT     3
`define ST_WAKE_ONE_BIT     2

// reset values
`define SLEEP_CTRL_RESET    2'h2
`define OVERHEAT_EN_RESET   1'h1
`define LOCK_OPT_RESET      1'h1
`define OTD_THRESH_RESET    2'h2
`define BALANCE_RESET       8'h00

// timing: wake qualification time in microseconds at the system clock rate
`define CLK_FREQ_MHZ        40
`define WAKE_QUAL_US        1000
`define WAKE_QUAL_CYCLES    (`WAKE_QUAL_US * `CLK_FREQ_MHZ)

`endif

// ==== core/wake_qualifier.v ====
`timescale 1ns/1ps
`include "cell_monitor_defs.vh"

module wake_qualifier #(
    parameter integer QUAL_CYCLES = `WAKE_QUAL_CYCLES,
    parameter integer CNT_W       = 16
) (
    input  wire sys_clk,
    input  wire sys_rst,
    input  wire wake_pin,
    output reg  wake_status_q
);
    reg  [2:0]       sync_q;
    reg  [CNT_W-1:0] count_q;
    reg              level_q;
    wire             agree;
    wire             done;

    // three stages; only the last two are compared so the first never feeds logic
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], wake_pin};
        end
    end

    assign agree = (sync_q[1] == sync_q[2]);
    assign done  = (count_q >= QUAL_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});

    // a change only counts once the two late stages agree
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else if (agree) begin
            level_q <= sync_q[2];
        end
    end

    // qualification timer restarts whenever the pin drops early
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            count_q       <= {CNT_W{1'b0}};
            wake_status_q <= 1'b0;
        end else if (!level_q) begin
            count_q       <= {CNT_W{1'b0}};
            wake_status_q <= 1'b0;                                  // status drops at once
        end else if (!wake_status_q) begin
            if (done) begin
                wake_status_q <= 1'b1;
            end else begin
                count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // wake_qualifier

// ==== core/cell_monitor_control.v ====
// What this block does
// - tap switches close only with scan enabled
// - scan on: close switch code plus one
// - balance register at 01h, bit7 to switch8
// - any balance bit combination switches independently
// - balance holds until bit cleared or sleep-low
// - lockout option plus overheat: all balance off, latched
// - lockout releases only on 00h balance write
// - overheat detect needs enable and active balance
// - current monitor off when its enable is 0
// - zero force outputs centre level only
// - gain select picks gain 10 or 50
// - short detection runs only when enabled
// - sleep command enters sleep when wakes clear
// - wake active keeps sleep commands from entering sleep
// - sleep shuts drives down; zero force, gain and threshold select stay
// - wake input held 1 ms leaves sleep
// - wake status set restores sleep bits
// - discharge gates follow inputs, low in sleep
// - charge gate follows charge control input, low in sleep
`timescale 1ns/1ps
`include "cell_monitor_defs.vh"

module cell_monitor_control #(
    parameter integer WAKE_CYCLES = `WAKE_QUAL_CYCLES,
    parameter integer WAKE_CNT_W  = 16,
    parameter integer CELLS       = 8
) (
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire             reg_wr,
    input  wire             reg_rd,
    input  wire [7:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    output reg  [7:0]       reg_rdata_q,
    output reg              reg_rvalid_q,
    input  wire             wake_input_one,
    input  wire             wake_input_two,
    input  wire             overheat_threshold,
    input  wire             discharge_ctrl_a,
    input  wire             discharge_ctrl_b,
    input  wire             charge_ctrl_in,
    output reg  [CELLS-1:0] tap_switch_q,
    output reg  [CELLS-1:0] balance_switch_q,
    output reg              current_monitor_on_q,
    output reg              zero_force_q,
    output reg              gain_high_q,
    output reg              short_protect_on_q,
    output reg  [1:0]       overheat_thresh_sel_q,
    output reg              overheat_detect_on_q,
    output reg              discharge_gate_a_q,
    output reg              discharge_gate_b_q,
    output reg              charge_gate_out_q,
    output reg              regulator_output_q,
    output reg              sleep_q
);
    // one-hot tap decode
    function [CELLS-1:0] tap_decode;
        input       enable;
        input [2:0] code;
        begin
            tap_decode = {CELLS{1'b0}};
            if (enable) begin
                tap_decode[code] = 1'b1;
            end
        end
    endfunction

    // software-written control state
    reg  [1:0]       sleep_ctrl_q;
    reg              scan_enable_q;
    reg  [2:0]       cell_select_q;
    reg  [CELLS-1:0] balance_bits_q;
    reg              cur_mon_en_q;
    reg              zero_force_ctl_q;
    reg              gain_select_q;
    reg              short_en_q;
    reg              overheat_detect_enable_q;
    reg              overheat_lockout_option_q;
    reg  [1:0]       otd_thresh_q;

    // block state
    reg              lockout_q;
    reg              otd_status_q;
    reg              wake_one_prev_q;
    reg              wake_two_prev_q;

    // pin synchronisers, three stages each; bit order one per input
    reg  [2:0]       otd_sync_q;
    reg  [2:0]       dis_a_sync_q;
    reg  [2:0]       dis_b_sync_q;
    reg  [2:0]       chg_sync_q;
    reg              otd_pin_q;
    reg              dis_a_q;
    reg              dis_b_q;
    reg              chg_q;

    wire             wake_status_one;
    wire             wake_status_two;
    wire             wake_any;
    wire             wake_rise;
    wire             wr_mode;
    wire             wr_bal;
    wire             wr_ana;
    wire             wr_otd;
    wire             sleep_cmd;
    wire             balance_active;
    wire             otd_detect_active;
    wire             lock_set;
    wire             lock_release;
    wire [7:0]       status_byte;

    // two independent wake channels share one qualifier design
    wake_qualifier #(
        .QUAL_CYCLES (WAKE_CYCLES),
        .CNT_W       (WAKE_CNT_W)
    ) u_wake_one (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .wake_pin      (wake_input_one),
        .wake_status_q (wake_status_one)
    );

    wake_qualifier #(
        .QUAL_CYCLES (WAKE_CYCLES),
        .CNT_W       (WAKE_CNT_W)
    ) u_wake_two (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .wake_pin      (wake_input_two),
        .wake_status_q (wake_status_two)
    );

    assign wake_any  = wake_status_one | wake_status_two;
    assign wake_rise = (wake_status_one & ~wake_one_prev_q) | (wake_status_two & ~wake_two_prev_q);

    // write decode
    assign wr_mode   = reg_wr && (reg_addr == `REG_MODE_ADDR);
    assign wr_bal    = reg_wr && (reg_addr == `REG_BALANCE_ADDR);
    assign wr_ana    = reg_wr && (reg_addr == `REG_ANALOG_ADDR);
    assign wr_otd    = reg_wr && (reg_addr == `REG_OVERHEAT_ADDR);
    assign sleep_cmd = wr_mode && reg_wdata[`MODE_SLEEP_LOW_BIT];

    assign balance_active    = |balance_switch_q;
    assign otd_detect_active = overheat_detect_enable_q && balance_active;
    assign lock_set          = overheat_lockout_option_q && otd_status_q;
    assign lock_release      = wr_bal && (reg_wdata == 8'h00);

    // pin synchronisers: a level is taken once stages two and three agree
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            otd_sync_q   <= 3'h0;
            dis_a_sync_q <= 3'h0;
            dis_b_sync_q <= 3'h0;
            chg_sync_q   <= 3'h0;
            otd_pin_q    <= 1'b0;
            dis_a_q      <= 1'b0;
            dis_b_q      <= 1'b0;
            chg_q        <= 1'b0;
        end else begin
            otd_sync_q   <= {otd_sync_q[1:0], overheat_threshold};
            dis_a_sync_q <= {dis_a_sync_q[1:0], discharge_ctrl_a};
            dis_b_sync_q <= {dis_b_sync_q[1:0], discharge_ctrl_b};
            chg_sync_q   <= {chg_sync_q[1:0], charge_ctrl_in};
            if (otd_sync_q[1] == otd_sync_q[2]) otd_pin_q <= otd_sync_q[2];
            if (dis_a_sync_q[1] == dis_a_sync_q[2]) dis_a_q <= dis_a_sync_q[2];
            if (dis_b_sync_q[1] == dis_b_sync_q[2]) dis_b_q <= dis_b_sync_q[2];
            if (chg_sync_q[1] == chg_sync_q[2]) chg_q <= chg_sync_q[2];
        end
    end

    // mode register and sleep sequencing
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sleep_ctrl_q    <= `SLEEP_CTRL_RESET;
            scan_enable_q   <= 1'b0;
            cell_select_q   <= 3'h0;
            sleep_q         <= 1'b0;
            wake_one_prev_q <= 1'b0;
            wake_two_prev_q <= 1'b0;
        end else begin
            wake_one_prev_q <= wake_status_one;
            wake_two_prev_q <= wake_status_two;
            if (wr_mode) begin
                scan_enable_q <= reg_wdata[`MODE_SCAN_EN_BIT];
                cell_select_q <= reg_wdata[`MODE_SEL_MSB:`MODE_SEL_LSB];
            end
            // a fresh wake wins over a sleep write landing in the same cycle
            if (wake_rise) begin
                sleep_ctrl_q <= `SLEEP_CTRL_RESET;
                sleep_q      <= 1'b0;
            end else if (wr_mode) begin
                sleep_ctrl_q <= reg_wdata[`MODE_SLEEP_HIGH_BIT:`MODE_SLEEP_LOW_BIT];
                if (sleep_cmd && !wake_any) begin
                    sleep_q <= 1'b1;
                end                                                          // dropped while awake
            end
        end
    end

    // balance register, with its sleep clear and lockout release
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            balance_bits_q <= `BALANCE_RESET;
            lockout_q      <= 1'b0;
        end else begin
            if (wr_bal) begin
                balance_bits_q <= reg_wdata[CELLS-1:0];
            end else if (sleep_cmd) begin
                balance_bits_q <= {CELLS{1'b0}};
            end
            // a new overheat event outranks a release in the same cycle
            if (lock_set) begin
                lockout_q <= 1'b1;
            end else if (lock_release) begin
                lockout_q <= 1'b0;
            end
        end
    end

    // analog and overheat control registers
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cur_mon_en_q              <= 1'b0;
            zero_force_ctl_q          <= 1'b0;
            gain_select_q             <= 1'b0;
            short_en_q                <= 1'b0;
            overheat_detect_enable_q  <= `OVERHEAT_EN_RESET;
            overheat_lockout_option_q <= `LOCK_OPT_RESET;
            otd_thresh_q              <= `OTD_THRESH_RESET;
        end else begin
            if (wr_ana) begin
                cur_mon_en_q     <= reg_wdata[`ANA_CUR_MON_EN_BIT];
                zero_force_ctl_q <= reg_wdata[`ANA_ZERO_FORCE_BIT];
                gain_select_q    <= reg_wdata[`ANA_GAIN_SEL_BIT];
                short_en_q       <= reg_wdata[`ANA_SHORT_EN_BIT];
            end
            if (wr_otd) begin
                overheat_detect_enable_q  <= reg_wdata[`OTD_DETECT_EN_BIT];
                overheat_lockout_option_q <= reg_wdata[`OTD_LOCK_OPT_BIT];
                otd_thresh_q              <= reg_wdata[`OTD_THRESH_MSB:`OTD_THRESH_LSB];
            end
        end
    end

    // overheat status only tracks the sensor while detection is armed
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            otd_status_q <= 1'b0;
        end else begin
            otd_status_q <= otd_detect_active && otd_pin_q;
        end
    end

    // switch and gate drives; sleep forces all but zero force, gain and threshold select off
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            tap_switch_q          <= {CELLS{1'b0}};
            balance_switch_q      <= {CELLS{1'b0}};
            current_monitor_on_q  <= 1'b0;
            zero_force_q          <= 1'b0;
            gain_high_q           <= 1'b0;
            short_protect_on_q    <= 1'b0;
            overheat_thresh_sel_q <= `OTD_THRESH_RESET;
            overheat_detect_on_q  <= 1'b0;
            discharge_gate_a_q    <= 1'b0;
            discharge_gate_b_q    <= 1'b0;
            charge_gate_out_q     <= 1'b0;
            regulator_output_q    <= 1'b1;
        end else begin
            tap_switch_q          <= sleep_q ? {CELLS{1'b0}} :
                                     tap_decode(scan_enable_q, cell_select_q);
            // lockout masks bits but keeps them stored; the 00h write that releases it also clears them
            balance_switch_q      <= (sleep_q || lockout_q || lock_set) ? {CELLS{1'b0}} :
                                     balance_bits_q;
            current_monitor_on_q  <= cur_mon_en_q && !sleep_q;
            zero_force_q          <= zero_force_ctl_q;
            gain_high_q           <= gain_select_q;
            short_protect_on_q    <= short_en_q && !sleep_q;
            overheat_thresh_sel_q <= otd_thresh_q;
            overheat_detect_on_q  <= otd_detect_active;
            discharge_gate_a_q    <= dis_a_q && !sleep_q;
            discharge_gate_b_q    <= dis_b_q && !sleep_q;
            charge_gate_out_q     <= chg_q && !sleep_q;
            regulator_output_q    <= !sleep_q;
        end
    end

    // status byte reflects live gate and wake state
    assign status_byte = {charge_gate_out_q, discharge_gate_b_q, discharge_gate_a_q,
                          otd_status_q, wake_status_two, wake_status_one, 2'h0};

    // register read: one cycle after the strobe, unmapped commands return zero
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `REG_MODE_ADDR:     reg_rdata_q <= {sleep_ctrl_q, 2'h0, scan_enable_q, cell_select_q};
                    `REG_BALANCE_ADDR:  reg_rdata_q <= balance_bits_q;
                    `REG_ANALOG_ADDR:   reg_rdata_q <= {4'h0, short_en_q, gain_select_q,
                                                        zero_force_ctl_q, cur_mon_en_q};
                    `REG_OVERHEAT_ADDR: reg_rdata_q <= {overheat_detect_enable_q, 2'h0,
                                                        overheat_lockout_option_q, 2'h0, otd_thresh_q};
                    `REG_STATUS_ADDR:   reg_rdata_q <= status_byte;
                    default:            reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end
endmodule // cell_monitor_control

// ==== dv/cell_monitor_checker.sv ====
`timescale 1ns/1ps
module cell_monitor_checker #(
    parameter integer WAKE_CYCLES = 40000
) (
    input wire       sys_clk,
    input wire       sys_rst,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_q,
    input wire       reg_rvalid_q,
    input wire       wake_input_one,
    input wire       wake_input_two,
    input wire       overheat_threshold,
    input wire       discharge_ctrl_a,
    input wire       charge_ctrl_in,
    input wire [7:0] tap_switch_q,
    input wire [7:0] balance_switch_q,
    input wire       current_monitor_on_q,
    input wire       zero_force_q,
    input wire       gain_high_q,
    input wire       short_protect_on_q,
    input wire       discharge_gate_a_q,
    input wire       discharge_gate_b_q,
    input wire       charge_gate_out_q,
    input wire       regulator_output_q,
    input wire       sleep_q
);
    reg  [7:0]  wd1_q, wd2_q, ot_q;
    reg  [1:0]  bw_q;
    reg  [2:0]  sl_q;
    reg  [5:0]  da_q, dc_q;
    reg  [3:0]  wl_q;
    reg  [15:0] wh_q;
    wire        wake_any = wake_input_one | wake_input_two;
    wire        wm = reg_wr && reg_addr == 8'h00;
    // history; counters saturate so idle never wraps
    always @(posedge sys_clk) begin
        wd1_q <= reg_wdata;
        wd2_q <= wd1_q;
        da_q  <= {da_q[4:0], discharge_ctrl_a};
        dc_q  <= {dc_q[4:0], charge_ctrl_in};
        if (sys_rst) begin
            {bw_q, sl_q, ot_q, wl_q, wh_q} <= 33'h0;
        end else begin
            bw_q <= {bw_q[0], reg_wr && reg_addr == 8'h01};
            sl_q <= {sl_q[1:0], wm && reg_wdata[6]};
            ot_q <= {ot_q[6:0], overheat_threshold};
            wl_q <= wake_any ? 4'h0 : (wl_q == 4'hf ? wl_q : wl_q + 4'h1);
            wh_q <= !wake_any ? 16'h0 : (wh_q == 16'hffff ? wh_q : wh_q + 16'h1);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_tap_select: assert property ((wm && !reg_wdata[6]) |-> ##2
        (sleep_q || tap_switch_q == (wd2_q[3] ? 8'h01 << wd2_q[2:0] : 8'h00))) else $error("tap mismatch");
    a_tap_onehot: assert property ($onehot0(tap_switch_q)) else $error("tap not one-hot");
    a_balance_rise: assert property (|(balance_switch_q & ~$past(balance_switch_q)) |-> bw_q[1])
        else $error("balance on without write");
    a_balance_fall: assert property (|($past(balance_switch_q) & ~balance_switch_q) |->
        (bw_q[1] || sleep_q || |sl_q || |ot_q)) else $error("balance dropped without cause");
    a_sleep_quiet: assert property (sleep_q && $past(sleep_q) |-> {tap_switch_q, balance_switch_q,
        current_monitor_on_q, short_protect_on_q, discharge_gate_a_q, discharge_gate_b_q,
        charge_gate_out_q, regulator_output_q} == 22'h0) else $error("drive active in sleep");
    a_sleep_entry: assert property ((wm && reg_wdata[6] && wl_q >= 4'hc)
        |-> ##[1:3] sleep_q) else $error("sleep not entered");
    a_sleep_refused: assert property ((wm && reg_wdata[6]
        && wh_q > WAKE_CYCLES + 8) |=> !sleep_q [*3]) else $error("sleep taken while waking");
    a_wake_exit: assert property ($fell(sleep_q) |-> wh_q >= WAKE_CYCLES) else $error("early wake");
    a_monitor_ctrl: assert property (reg_wr && reg_addr == 8'h02 |-> ##2 (sleep_q ||
        (current_monitor_on_q == wd2_q[0] && short_protect_on_q == wd2_q[3]))) else $error("monitor ctrl");
    a_analog_pass: assert property (reg_wr && reg_addr == 8'h02 |-> ##2
        (zero_force_q == wd2_q[1] && gain_high_q == wd2_q[2])) else $error("zero or gain");
    a_read_answer: assert property (reg_rd |=> reg_rvalid_q) else $error("no read answer");
    a_gate_follow: assert property ((da_q == 6'h3f || da_q == 6'h00) && !sleep_q && !$past(sleep_q)
        |-> discharge_gate_a_q == da_q[0]) else $error("discharge gate");
    a_charge_follow: assert property ((dc_q == 6'h3f || dc_q == 6'h00) && !sleep_q && !$past(sleep_q)
        |-> charge_gate_out_q == dc_q[0]) else $error("charge gate");
endmodule // cell_monitor_checker
bind cell_monitor_control cell_monitor_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.*);

// ==== dv/reg_master.sv ====
`timescale 1ns/1ps
module reg_master (
    input  wire       sys_clk,
    output reg        reg_wr,
    output reg        reg_rd,
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata,
    input  wire [7:0] reg_rdata_q,
    input  wire       reg_rvalid_q
);
    integer i;
    // idle state at time zero
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    end
    // one write per call; released lines inverted
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= (a == 8'h01) ? (d & ~(d << 1)) : d;
            @(posedge sys_clk);
            reg_wr    <= 1'b0;
            reg_wdata <= ~reg_wdata;
            reg_addr  <= ~reg_addr;
        end
    endtask
    // read, bounded wait for the answer
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge sys_clk);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd   <= 1'b0;
            reg_addr <= ~a;
            for (i = 0; i < 4 && reg_rvalid_q !== 1'b1; i = i + 1)
                @(posedge sys_clk);
            d = reg_rdata_q;
        end
    endtask
endmodule // reg_master

// ==== dv/tb_cell_monitor_control.sv ====
`timescale 1ns/1ps
module tb_cell_monitor_control;
    localparam integer WAKE = 20;
    reg        sys_clk, sys_rst, wake_input_one, wake_input_two, overheat_threshold;
    reg        discharge_ctrl_a, discharge_ctrl_b, charge_ctrl_in;
    wire       reg_wr, reg_rd, reg_rvalid_q, current_monitor_on_q, zero_force_q, gain_high_q, sleep_q;
    wire       short_protect_on_q, overheat_detect_on_q, discharge_gate_a_q, discharge_gate_b_q;
    wire       charge_gate_out_q, regulator_output_q;
    wire [1:0] overheat_thresh_sel_q;
    wire [7:0] reg_addr, reg_wdata, reg_rdata_q, tap_switch_q, balance_switch_q;
    wire [7:0] drv = {4'h0, regulator_output_q, charge_gate_out_q, discharge_gate_b_q, discharge_gate_a_q};
    integer    n_errors, checks, k;
    reg [31:0] seed;
    reg [7:0]  v, rv;
    cell_monitor_control #(.WAKE_CYCLES(WAKE)) dut (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .wake_input_one, .wake_input_two, .overheat_threshold,
        .discharge_ctrl_a, .discharge_ctrl_b, .charge_ctrl_in, .tap_switch_q, .balance_switch_q,
        .current_monitor_on_q, .zero_force_q, .gain_high_q, .short_protect_on_q, .overheat_thresh_sel_q,
        .overheat_detect_on_q, .discharge_gate_a_q, .discharge_gate_b_q, .charge_gate_out_q,
        .regulator_output_q, .sleep_q);
    reg_master u_mst (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q);
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] tap_exp(input [3:0] m);
        tap_exp = m[3] ? (8'h01 << m[2:0]) : 8'h00;
    endfunction
    task chk(input [8*10-1:0] name, input [7:0] exp, input [7:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
                n_errors = n_errors + 1;
            end
        end
    endtask
    // settle past the edge before sampling outputs
    task cyc(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            u_mst.rd(a, rv);
            chk("readback", exp, rv);
        end
    endtask
    task wake(input integer p, input val);
        begin
            @(posedge sys_clk);
            if (p == 0) wake_input_one <= val;
            else wake_input_two <= val;
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // hang guard, far past the test length
    initial begin
        #(25 * 30000);
        n_errors = n_errors + 1;
        $display("watchdog expired");
        finish_test;
    end
    initial begin
        {n_errors, checks} = 0;
        seed = 32'h5e4970b0;
        {sys_rst, wake_input_one, wake_input_two, overheat_threshold} = 4'h8;
        {discharge_ctrl_a, discharge_ctrl_b, charge_ctrl_in} = 3'h0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cyc(1);
        chk("tap", 8'h00, tap_switch_q);
        chk("thresh", 8'h02, {6'h0, overheat_thresh_sel_q});
        chk("regulator", 8'h01, {7'h0, regulator_output_q});
        rchk(8'h00, 8'h80);
        rchk(8'h01, 8'h00);
        rchk(8'h06, 8'h92);
        rchk(8'h07, 8'h00);
        rchk(8'h05, 8'h00);
        $display("reset test done");
        // every scan code, balancing off
        for (k = 0; k < 16; k = k + 1) begin
            u_mst.wr(8'h00, {4'h8, k[3:0]});
            cyc(3);
            chk("tap", tap_exp(k[3:0]), tap_switch_q);
        end
        u_mst.wr(8'h00, 8'h80);
        $display("tap test done");
        for (k = 0; k < 12; k = k + 1) begin
            seed = lfsr(seed);
            v = (k == 0) ? 8'h55 : seed[7:0] & ~(seed[7:0] << 1);
            u_mst.wr(8'h01, v);
            cyc(3);
            chk("balance", v, balance_switch_q);
            rchk(8'h01, v);
        end
        u_mst.wr(8'h01, 8'h05);
        u_mst.wr(8'h01, 8'h04);
        cyc(20);
        chk("balance", 8'h04, balance_switch_q);
        chk("armed", 8'h01, {7'h0, overheat_detect_on_q});
        $display("balance test done");
        // lockout latch and its release
        overheat_threshold <= 1'b1;
        cyc(10);
        chk("balance", 8'h00, balance_switch_q);
        rchk(8'h01, 8'h04);
        overheat_threshold <= 1'b0;
        u_mst.wr(8'h01, 8'h05);
        cyc(3);
        chk("balance", 8'h00, balance_switch_q);
        u_mst.wr(8'h01, 8'h00);
        u_mst.wr(8'h01, 8'h05);
        cyc(3);
        chk("balance", 8'h05, balance_switch_q);
        u_mst.wr(8'h06, 8'h12);
        cyc(3);
        chk("armed", 8'h00, {7'h0, overheat_detect_on_q});
        overheat_threshold <= 1'b1;
        cyc(10);
        chk("balance", 8'h05, balance_switch_q);
        u_mst.wr(8'h06, 8'h83);
        cyc(10);
        chk("balance", 8'h05, balance_switch_q);
        chk("thresh", 8'h03, {6'h0, overheat_thresh_sel_q});
        overheat_threshold <= 1'b0;
        u_mst.wr(8'h06, 8'h92);
        $display("lockout test done");
        for (k = 0; k < 16; k = k + 1) begin
            u_mst.wr(8'h02, {4'h0, k[3:0]});
            cyc(3);
            chk("analog", {4'h0, k[3:0]}, {4'h0, short_protect_on_q, gain_high_q, zero_force_q,
                current_monitor_on_q});
        end
        $display("analog test done");
        for (k = 0; k < 10; k = k + 1) begin
            seed = lfsr(seed);
            {charge_ctrl_in, discharge_ctrl_b, discharge_ctrl_a} <= seed[2:0];
            cyc(7);
            chk("gates", {5'h0, seed[2:0]}, {5'h0, charge_gate_out_q, discharge_gate_b_q,
                discharge_gate_a_q});
            rchk(8'h07, {seed[2:0], 5'h0});
        end
        $display("gate test done");
        // sleep, short pulse, real wake, refused sleep, per pin
        for (k = 0; k < 2; k = k + 1) begin
            u_mst.wr(8'h01, 8'h05);
            {charge_ctrl_in, discharge_ctrl_b, discharge_ctrl_a} <= 3'h7;
            u_mst.wr(8'h00, 8'h48);
            cyc(4);
            chk("sleep", 8'h01, {7'h0, sleep_q});
            chk("drives", 8'h00, balance_switch_q | tap_switch_q);
            chk("gates", 8'h00, drv);
            rchk(8'h01, 8'h00);
            wake(k, 1'b1);
            cyc(WAKE / 2);
            wake(k, 1'b0);
            cyc(WAKE + 10);
            chk("sleep", 8'h01, {7'h0, sleep_q});
            wake(k, 1'b1);
            cyc(WAKE + 12);
            chk("sleep", 8'h00, {7'h0, sleep_q});
            chk("gates", 8'h0f, drv);
            rchk(8'h00, 8'h88);
            rchk(8'h07, k ? 8'he8 : 8'he4);
            u_mst.wr(8'h00, 8'h40);
            cyc(4);
            chk("sleep", 8'h00, {7'h0, sleep_q});
            u_mst.wr(8'h00, 8'h80);
            wake(k, 1'b0);
            cyc(10);
            rchk(8'h07, 8'he0);
        end
        $display("sleep test done");
        finish_test;
    end
endmodule // tb_cell_monitor_control
